/* branch_and_bit_set_execute.sv */
// Phase sequencer and execute stage for the relative branches and the bit-set instruction.
// Assumes the fetch path presents the word and the advanced counter during Q1,
// the flags are stable from same-clock logic, and read data returns by the end of Q2.
module branch_and_bit_set_execute
    import branch_exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT,
    parameter int BANK_W = 4
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [15:0] fetch_word,
    input wire logic [PC_W-1:0] pc_next,
    input wire status_flags_t flags,
    input wire logic [BANK_W-1:0] bank_select_reg,
    input wire logic [7:0] rd_data,
    output q_phase_t phase,
    output logic rd_en,
    output logic [11:0] rd_addr,
    output logic wr_en,
    output reg_access_t wr,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    output logic flush,
    output logic flags_we
);
    // Refuse shapes the address and target logic cannot serve, at elaboration.
    if (BANK_W != 4)
    begin : g_bad_bank
        $error("BANK_W must be 4 to form a 12-bit register address.");
    end
    if (PC_W < LONG_OFF_W + 2)
    begin : g_bad_pc
        $error("PC_W is too narrow for the long branch offset.");
    end

    // Phase counter, instruction register and captured counter.
    q_phase_t phase_ff;
    q_phase_t nxt_phase;
    logic [15:0] ir_ff;
    logic [PC_W-1:0] pc_ff;
    // Set while the idle second cycle of a taken branch runs.
    logic nop_ff;
    // Set when the latched instruction is to be executed.
    logic live_ff;
    // Branch decision taken in Q2 for use in Q4.
    logic take_ff;
    // Modified byte held from Q3 into Q4.
    logic [7:0] mod_ff;
    logic [11:0] addr_ff;
    // Read address formed from the incoming word so the file sees a flop, not a decode.
    // The bank select value is therefore taken at the end of Q1, one phase before the read.
    logic [11:0] rd_addr_ff;
    logic setbit_ff;
    // Registered output copies.
    logic rd_en_ff;
    logic wr_en_ff;
    logic pc_load_ff;
    logic [PC_W-1:0] target_ff;
    logic flush_ff;

    // Helper outputs for the latched word.
    instr_kind_t kind;
    logic cond_true;
    logic [PC_W-1:0] target;

    branch_target_calc #(
        .PC_W(PC_W)
    ) u_calc (
        .word(ir_ff),
        .pc_next(pc_ff),
        .flags(flags),
        .kind(kind),
        .cond_true(cond_true),
        .target(target)
    );

    // Register address of the arriving word: access bank splits at the midpoint, else banked.
    wire [7:0] f_addr = fetch_word[7:0];
    wire access_flag = fetch_word[ACCESS_FLAG_POS];
    wire [3:0] access_bank = (f_addr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    wire [3:0] eff_bank = access_flag ? bank_select_reg : access_bank;
    wire [11:0] eff_addr = {eff_bank, f_addr};

    // Bit index decoded to a one-hot mask.
    wire [2:0] bit_idx = ir_ff[BIT_IDX_LSB+2:BIT_IDX_LSB];
    wire [7:0] bit_mask = 8'h01 << bit_idx;
    // Other bits pass through unchanged from the byte just read.
    wire [7:0] set_byte = rd_data | bit_mask;

    // The branch is taken for every jump and for a true condition.
    wire do_branch = (kind == KIND_JUMP) | ((kind == KIND_COND) & cond_true);

    // Events keyed to the phase that is ending at this edge.
    wire end_q1 = phase_ff == PH_Q1;
    wire end_q2 = phase_ff == PH_Q2;
    wire end_q3 = phase_ff == PH_Q3;
    wire end_q4 = phase_ff == PH_Q4;

    // Phase advance: one quarter per edge, wrapping after Q4.
    always_comb
    begin
        unique case (phase_ff)
            PH_Q1: nxt_phase = PH_Q2;
            PH_Q2: nxt_phase = PH_Q3;
            PH_Q3: nxt_phase = PH_Q4;
            PH_Q4: nxt_phase = PH_Q1;
        endcase
    end

    // Phase counter.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            phase_ff <= PH_Q1;
        end
        else
        begin
            phase_ff <= nxt_phase;
        end
    end

    // Q1 decode: latch the word, marking it live unless this is the idle cycle of a branch.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ir_ff <= 16'h0000;
            pc_ff <= '0;
            rd_addr_ff <= 12'h000;
            live_ff <= 1'b0;
        end
        else if (end_q1)
        begin
            ir_ff <= fetch_word;
            pc_ff <= pc_next;
            rd_addr_ff <= eff_addr;
            live_ff <= ~nop_ff;
        end
    end

    // Q2 read: register read is issued while Q2 runs; the flags are judged at its end.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rd_en_ff <= 1'b0;
            addr_ff <= 12'h000;
            setbit_ff <= 1'b0;
            take_ff <= 1'b0;
        end
        else
        begin
            rd_en_ff <= end_q1 & ~nop_ff & (fetch_word[15:12] == OPC_SET_BIT);
            if (end_q2)
            begin
                addr_ff <= rd_addr_ff;
                setbit_ff <= live_ff & (kind == KIND_SETBIT);
                take_ff <= live_ff & do_branch;
            end
        end
    end

    // Q3 process: build the modified byte and the branch target.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            mod_ff <= 8'h00;
            target_ff <= '0;
        end
        else if (end_q2)
        begin
            mod_ff <= set_byte;
            target_ff <= target;
        end
    end

    // Q4 write: a single-phase strobe to the register file or counter.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            wr_en_ff <= 1'b0;
            pc_load_ff <= 1'b0;
        end
        else
        begin
            wr_en_ff <= end_q3 & setbit_ff;
            pc_load_ff <= end_q3 & take_ff;
        end
    end

    // A taken branch idles for exactly one following cycle; it never chains.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            nop_ff <= 1'b0;
            flush_ff <= 1'b0;
        end
        else if (end_q4)
        begin
            nop_ff <= take_ff & ~nop_ff;
            flush_ff <= take_ff & ~nop_ff;
        end
    end

    // The live flag and take flag must drop before the idle cycle's Q4.
    // This is already assured: live_ff is cleared in the idle cycle's Q1.

    // Outputs straight from flip-flops, except flags_we, which is tied low.
    assign phase = phase_ff;
    assign rd_en = rd_en_ff;
    // The read address stands from Q2 until the next word is latched.
    assign rd_addr = rd_addr_ff;
    assign wr_en = wr_en_ff;
    // One assignment for the whole write record keeps a single driver on the port.
    assign wr = '{addr: addr_ff, data: mod_ff};
    assign pc_load = pc_load_ff;
    assign pc_target = target_ff;
    assign flush = flush_ff;
    // None of these instructions touch the status flags.
    assign flags_we = 1'b0;
endmodule : branch_and_bit_set_execute

/* branch_and_bit_set_execute_properties.sv */
// Port checks for the branch and bit-set execute stage.
// Assumes one core clock and a synchronous active-low reset.
module branch_and_bit_set_execute_properties
    import branch_exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT,
    parameter int BANK_W = 4
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [15:0] fetch_word,
    input wire logic [PC_W-1:0] pc_next,
    input wire status_flags_t flags,
    input wire logic [BANK_W-1:0] bank_select_reg,
    input wire logic [7:0] rd_data,
    input wire q_phase_t phase,
    input wire logic rd_en,
    input wire logic [11:0] rd_addr,
    input wire logic wr_en,
    input wire reg_access_t wr,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic flush,
    input wire logic flags_we
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    logic [15:0] w_ff; // Word shadowed at the end of Q1.
    logic [PC_W-1:0] pc_ff; // Advanced counter shadowed with it.
    status_flags_t f_ff; // Flags as the stage sees them at the end of Q2.
    logic [BANK_W-1:0] b_ff; // Bank select shadowed with the word.
    // Shadowing the latches lets targets and addresses be predicted independently.
    always_ff @(posedge mclk)
    begin
        if (phase == PH_Q1)
        begin
            w_ff <= fetch_word;
            pc_ff <= pc_next;
            b_ff <= bank_select_reg;
        end
        if (phase == PH_Q2)
        begin
            f_ff <= flags;
        end
    end
    wire logic [7:0] op = w_ff[15:8];
    wire logic jmp = w_ff[15:11] == OPC_JUMP_ALWAYS;
    wire logic [PC_W-1:0] t_s = pc_ff + {{(PC_W-9){w_ff[7]}}, w_ff[7:0], 1'b0};
    wire logic [PC_W-1:0] t_l = pc_ff + {{(PC_W-12){w_ff[10]}}, w_ff[10:0], 1'b0};
    wire logic cnd = op == OPC_BRANCH_NOT_NEG || op == OPC_BRANCH_NO_OVF
        || op == OPC_BRANCH_NONZERO;
    wire logic ok = (op == OPC_BRANCH_NOT_NEG && !f_ff.negative)
        || (op == OPC_BRANCH_NO_OVF && !f_ff.overflow)
        || (op == OPC_BRANCH_NONZERO && !f_ff.zero);
    wire logic [3:0] ab = (w_ff[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    wire logic [11:0] ea = w_ff[ACCESS_FLAG_POS] ? {b_ff, w_ff[7:0]} : {ab, w_ff[7:0]};
    a_flags_kept: assert property (flags_we == 1'b0)
        else $error("flag write seen");
    a_read_addr: assert property (rd_en |-> phase == PH_Q2 && rd_addr == ea)
        else $error("bad read address or phase");
    a_set_read: assert property (phase == PH_Q2 && !flush
        && w_ff[15:12] == OPC_SET_BIT |-> rd_en) else $error("bit-set did not read");
    a_bit_write: assert property (rd_en |-> ##2 wr_en && wr.addr == $past(rd_addr, 2)
        && wr.data == ($past(rd_data, 2) | (8'h01 << w_ff[11:9]))) else $error("bad write");
    a_target_sum: assert property (pc_load |-> phase == PH_Q4
        && pc_target == (jmp ? t_l : t_s)) else $error("bad branch target");
    a_flush_span: assert property (pc_load |=> flush [*4] ##1 !flush)
        else $error("idle cycle length wrong");
    a_flush_quiet: assert property (flush |-> !rd_en && !wr_en && !pc_load)
        else $error("activity in idle cycle");
    a_jump_always: assert property (phase == PH_Q4 && jmp && !flush |-> pc_load)
        else $error("jump not taken");
    a_cond_pick: assert property (phase == PH_Q4
        && cnd && !flush |-> pc_load == ok) else $error("wrong branch decision");
endmodule : branch_and_bit_set_execute_properties

bind branch_and_bit_set_execute branch_and_bit_set_execute_properties
    #(.PC_W(PC_W), .BANK_W(BANK_W)) u_props (.mclk(mclk), .resetn(resetn),
    .fetch_word(fetch_word), .pc_next(pc_next), .flags(flags), .bank_select_reg(bank_select_reg),
    .rd_data(rd_data), .phase(phase), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr(wr),
    .pc_load(pc_load), .pc_target(pc_target), .flush(flush), .flags_we(flags_we));

/* branch_and_bit_set_execute_test.sv */
// Self-checking bench for the branch and bit-set execute stage.
// Assumes the register file model and the bound checker are compiled alongside.
module branch_and_bit_set_execute_test;
    timeunit 1ns;
    timeprecision 1ns;
    import branch_exec_pkg::*;
    logic mclk, resetn, rd_en, wr_en, pc_load, flush, flags_we;
    logic [15:0] fetch_word;
    logic [20:0] pc_next, pc_target;
    status_flags_t flags;
    logic [3:0] bank_select_reg;
    logic [7:0] rd_data;
    logic [11:0] rd_addr;
    q_phase_t phase;
    reg_access_t wr;
    int mismatches = 0;
    int comparisons = 0;
    branch_and_bit_set_execute dut (.mclk(mclk), .resetn(resetn), .fetch_word(fetch_word),
        .pc_next(pc_next), .flags(flags), .bank_select_reg(bank_select_reg), .rd_data(rd_data),
        .phase(phase), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr(wr),
        .pc_load(pc_load), .pc_target(pc_target), .flush(flush), .flags_we(flags_we));
    regfile_model m (.mclk(mclk), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr(wr),
        .rd_data(rd_data));
    always #20 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One whole instruction cycle from Q1, plus the idle cycle when a branch is taken.
    task automatic issue(input logic [15:0] w, input logic [20:0] pc, input logic [2:0] f,
        input logic ld, input logic [20:0] t, input logic rd, input logic [11:0] a);
        fetch_word = w;
        pc_next = pc;
        flags = f;
        @(negedge mclk);
        chk(phase, PH_Q2);
        chk(rd_en, rd);
        if (rd) chk(rd_addr, a);
        repeat (2) @(negedge mclk);
        chk(phase, PH_Q4);
        chk(flags_we, 1'b0);
        chk(pc_load, ld);
        if (ld) chk(pc_target, t);
        chk(wr_en, rd);
        if (rd) chk(wr, {a, (8'hA5 ^ a[7:0]) | (8'h01 << w[11:9])});
        repeat (ld ? 4 : 0)
        begin
            @(negedge mclk);
            fetch_word = 16'h87FF;
            chk(flush, 1'b1);
            chk(rd_en | wr_en, 1'b0);
        end
        @(negedge mclk);
        chk(flush, 1'b0);
    endtask : issue
    // Each condition taken both ways at the offset extremes, the other flags set against it.
    task automatic test_cond();
        logic [7:0] ops [3] = '{OPC_BRANCH_NOT_NEG, OPC_BRANCH_NO_OVF, OPC_BRANCH_NONZERO};
        logic [2:0] s;
        for (int k = 0; k < 3; k++)
        begin
            s = 3'b100 >> k;
            issue({ops[k], 8'h80}, 21'h001000, ~s, 1'b1, 21'h000F00, 1'b0, 12'h000);
            issue({ops[k], 8'h7F}, 21'h001000, 3'b000, 1'b1, 21'h0010FE, 1'b0, 12'h000);
            issue({ops[k], 8'h7F}, 21'h001000, s, 1'b0, 21'h000000, 1'b0, 12'h000);
        end
    endtask : test_cond
    // Long jump at both offset limits, the negative one wrapping the counter.
    task automatic test_jump();
        issue({OPC_JUMP_ALWAYS, 11'h400}, 21'h000010, 3'b111, 1'b1, 21'h1FF810,
            1'b0, 12'h000);
        issue({OPC_JUMP_ALWAYS, 11'h3FF}, 21'h000010, 3'b000, 1'b1, 21'h00080E,
            1'b0, 12'h000);
    endtask : test_jump
    // Back-to-back bit-sets across both access halves and the banked form.
    // Each chosen bit starts clear in the model, so a lost set shows in the written byte.
    task automatic test_set_bit();
        issue(16'h8A7F, 21'h000100, 3'b000, 1'b0, 21'h0, 1'b1, 12'h07F);
        issue(16'h8E80, 21'h000102, 3'b111, 1'b0, 21'h0, 1'b1, 12'hF80);
        issue(16'h8780, 21'h000104, 3'b000, 1'b0, 21'h0, 1'b1, 12'h580);
        issue(16'h0000, 21'h000106, 3'b000, 1'b0, 21'h0, 1'b0, 12'h000);
    endtask : test_set_bit
    task automatic results();
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        fetch_word = 16'h0000;
        pc_next = 21'h000000;
        flags = 3'b000;
        bank_select_reg = 4'h5;
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        test_cond();
        test_jump();
        test_set_bit();
        results();
    end
    // Cuts a hang short well after the 96 clock cycles the tests need, reset included.
    initial
    begin
        #100us;
        mismatches++;
        results();
    end
endmodule : branch_and_bit_set_execute_test

/* branch_exec_pkg.sv */
// Shared constants, types and the branch target helper for the branch and bit-set group.
// Assumes one core clock where each edge advances one quarter (phase) of an instruction cycle.
// Function
// - Double the signed offset before adding.
// - Target is advanced counter plus twice offset.
// - Conditional offset is low byte, signed.
// - Not-negative branches only when negative clear.
// - Not-overflow decoded E5, branches when clear.
// - Nonzero branches only when zero flag clear.
// - Nonzero decoded from upper byte E1.
// - One word; one cycle, two when taken.
// - Taken: write counter in Q4, then idle.
// - Jump offset is signed eleven bits.
// - Jump decoded from top bits 11010.
// - Jump always two cycles, second idle.
// - Bit-set forces indexed bit of register.
// - Access flag zero selects access bank.
// - Access flag one uses bank select.
// - Not-negative decoded from upper byte E7.
package branch_exec_pkg;
    // Opcode patterns of the instructions this block executes.
    localparam logic [7:0] OPC_BRANCH_NOT_NEG = 8'hE7;
    localparam logic [7:0] OPC_BRANCH_NO_OVF = 8'hE5;
    localparam logic [7:0] OPC_BRANCH_NONZERO = 8'hE1;
    localparam logic [4:0] OPC_JUMP_ALWAYS = 5'h1A;
    localparam logic [3:0] OPC_SET_BIT = 4'h8;
    // Field positions inside the instruction word.
    localparam int SHORT_OFF_W = 8;
    localparam int LONG_OFF_W = 11;
    localparam int BIT_IDX_LSB = 9;
    localparam int ACCESS_FLAG_POS = 8;
    // Access bank layout: low half in the lowest bank, high half in the top bank.
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // Default program counter width in bits.
    localparam int PC_W_DEFAULT = 21;

    // The four quarters of an instruction cycle.
    typedef enum logic [1:0]
    {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } q_phase_t;

    // Instruction classes this block recognises.
    typedef enum logic [1:0]
    {
        KIND_OTHER = 2'b00,
        KIND_COND = 2'b01,
        KIND_JUMP = 2'b10,
        KIND_SETBIT = 2'b11
    } instr_kind_t;

    // Status flags consumed by the conditional branches.
    typedef struct packed
    {
        logic negative;
        logic overflow;
        logic zero;
    } status_flags_t;

    // One register write: banked address and byte.
    typedef struct packed
    {
        logic [11:0] addr;
        logic [7:0] data;
    } reg_access_t;
endpackage : branch_exec_pkg

// Classifies an instruction word, evaluates its branch condition and computes the target.
// Purely combinational; the caller registers everything it uses.
module branch_target_calc
    import branch_exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
)
(
    input wire logic [15:0] word,
    input wire logic [PC_W-1:0] pc_next,
    input wire status_flags_t flags,
    output instr_kind_t kind,
    output logic cond_true,
    output logic [PC_W-1:0] target
);
    // Upper-byte and top-bit decodes.
    wire is_bnn = word[15:8] == OPC_BRANCH_NOT_NEG;
    wire is_branch_no_overflow = word[15:8] == OPC_BRANCH_NO_OVF;
    wire is_bnz = word[15:8] == OPC_BRANCH_NONZERO;
    wire is_jump = word[15:11] == OPC_JUMP_ALWAYS;
    wire is_setbit = word[15:12] == OPC_SET_BIT;
    wire is_cond = is_bnn | is_branch_no_overflow | is_bnz;

    // Sign-extended offsets in words.
    wire [PC_W-1:0] short_off = {{(PC_W-SHORT_OFF_W){word[SHORT_OFF_W-1]}},
                                 word[SHORT_OFF_W-1:0]};
    wire [PC_W-1:0] long_off = {{(PC_W-LONG_OFF_W){word[LONG_OFF_W-1]}},
                                word[LONG_OFF_W-1:0]};
    wire [PC_W-1:0] sel_off = is_jump ? long_off : short_off;
    // Words become bytes: shift left by one.
    wire [PC_W-1:0] byte_off = {sel_off[PC_W-2:0], 1'b0};

    // The counter already points past the branch, so add directly.
    assign target = pc_next + byte_off;

    // Each conditional branch is taken only on a clear flag.
    assign cond_true = (is_bnn & ~flags.negative)
                     | (is_branch_no_overflow & ~flags.overflow)
                     | (is_bnz & ~flags.zero);

    // Class priority does not matter: the patterns cannot overlap.
    assign kind = is_setbit ? KIND_SETBIT :
                  is_jump ? KIND_JUMP :
                  is_cond ? KIND_COND : KIND_OTHER;
endmodule : branch_target_calc

/* regfile_model.sv */
// Behavioural banked register file behind the execute stage.
// Assumes reads are combinational during rd_en and writes land on the clock.
module regfile_model
    import branch_exec_pkg::*;
(
    input wire logic mclk,
    input wire logic rd_en,
    input wire logic [11:0] rd_addr,
    input wire logic wr_en,
    input wire reg_access_t wr,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:4095]; // Each byte starts as 8'hA5 xor its low address.
    // Unselected, the bus shows the inverse so a stale sample cannot pass.
    assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
    initial
    begin
        for (int i = 0; i < 4096; i++)
        begin
            mem[i] = 8'hA5 ^ i[7:0];
        end
    end
    // Store the full byte that the stage rewrites.
    always @(posedge mclk)
    begin
        if (wr_en)
        begin
            mem[wr.addr] <= wr.data;
        end
    end
endmodule : regfile_model
